// file: hw/ppdm_map.vh
// Constants for the ping-pong data memory control block
// Function
// - Two banks, 1K deep, 32 bits wide
// - Bank select swaps left and right address buses
// - Only processed bank's DSP transceivers enabled
// - DSP transceiver direction follows microword write bits
// - Word host transfer enables first and third lanes
// - Byte host: low byte first, then high
// - Low byte write also drives junk high byte
// - Host lanes point inward except during read
// - Four host chip enables from bank, strobe
// - Eight separate memory write-enable lines
// - DSP writes whole words from two bits
// - Two I/O addresses give high/low byte strobes
// - I/O write enables from byte strobes, upper enable
// - Write bits steer shifter and buffer enables
// - Byte mode counter advances every two accesses
// - Instruction bit seven sets bank select latch
`ifndef PPDM_MAP_VH
`define PPDM_MAP_VH

// =====================================================================
// Memory geometry
`define PPDM_BANK_DEPTH      1024
`define PPDM_BANK_AW         10
`define PPDM_HALF_WIDTH      16
`define PPDM_CNT_W           12

// =====================================================================
// Register byte offsets on the Wishbone bus
`define PPDM_OFF_INSTR       4'h0
`define PPDM_OFF_HADDR       4'h4
`define PPDM_OFF_CTRL        4'h8
`define PPDM_OFF_STATUS      4'hC

// =====================================================================
// Field positions
`define PPDM_INSTR_BANK_BIT  7
`define PPDM_CTRL_BYTE_BIT   0
`define PPDM_ST_BANK_BIT     0
`define PPDM_ST_PEND_BIT     1
`define PPDM_ST_PHASE_BIT    2
`define PPDM_ST_HBUSY_BIT    3
`define PPDM_ST_DRUN_BIT     4

// =====================================================================
// Reset values
`define PPDM_INSTR_RST       8'h00
`define PPDM_HADDR_RST       12'h000
`define PPDM_CTRL_RST        1'b0
`define PPDM_BANK_RST        1'b0

// =====================================================================
// Host I/O decode: the two data addresses inside the board's window
`define PPDM_IO_HIGH_ADDR    5'h00
`define PPDM_IO_LOW_ADDR     5'h01

// =====================================================================
// Synchroniser depth for host pins
`define PPDM_SYNC_STAGES     3

`endif

// file: hw/ppdm_pin_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module ppdm_pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] pin_i,
  output reg  [WIDTH-1:0] level_o
);

  // =====================================================================
  // Synchroniser stages
  reg [WIDTH-1:0] stage1;   // Metastable stage, read only by stage2
  reg [WIDTH-1:0] stage2;   // First settled stage
  reg [WIDTH-1:0] stage3;   // Second settled stage

  // Chain of three flops; one-cycle glitches never reach the output
  always @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
    end else begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // =====================================================================
  // Agreement filter, per bit
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      // A change counts only once stage2 and stage3 agree
      always @(posedge clk_i) begin
        if (rst_i) begin
          level_o[g] <= 1'b0;
        end else if (stage2[g] == stage3[g]) begin
          level_o[g] <= stage3[g];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// file: hw/ppdm_ctrl.v
// Ping-pong data memory control: bank swap, lanes, enables, registers
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "ppdm_map.vh"

module ppdm_ctrl #(
  parameter AW = `PPDM_BANK_AW,   // Bank address width, 1K deep
  parameter CW = `PPDM_CNT_W      // Fly-by counter width
) (
  input  wire          clk_i,
  input  wire          rst_i,
  // Wishbone classic slave
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [3:0]    wb_adr_i,
  input  wire [3:0]    wb_sel_i,
  input  wire [31:0]   wb_dat_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  // Host bus pins, asynchronous to clk_i
  input  wire          host_read_strobe_i,
  input  wire          host_write_strobe_i,
  input  wire          host_io_select_i,
  input  wire [4:0]    host_io_addr_i,
  input  wire          upper_lane_bus_enable_i,
  input  wire          host_dma_ack_i,
  // Microword and sequencer, same clock
  input  wire          ucode_we_real_i,
  input  wire          ucode_we_imag_i,
  input  wire          dsp_run_i,
  // Address bus steering
  output reg           left_addr_from_dsp_o,
  output reg           right_addr_from_dsp_o,
  output reg  [AW-1:0] host_mem_addr_o,
  // DSP-side bank transceivers
  output reg           dsp_left_xcvr_enable_o,
  output reg           dsp_right_xcvr_enable_o,
  output reg           dsp_real_xcvr_to_mem_o,
  output reg           dsp_imag_xcvr_to_mem_o,
  // Shifter and return buffer output enables
  output reg           shifter_real_oe_o,
  output reg           shifter_imag_oe_o,
  output reg           return_real_oe_o,
  output reg           return_imag_oe_o,
  // Host lane transceivers
  output reg           word_lane_xcvr_enable_o,
  output reg           high_lane_xcvr_enable_o,
  output reg           host_lane_to_host_o,
  // Host-side chip enables
  output reg           left_real_host_enable_o,
  output reg           left_imag_host_enable_o,
  output reg           right_real_host_enable_o,
  output reg           right_imag_host_enable_o,
  // Memory write enables: {bank, half, byte}, first lane is bit 0
  output reg  [7:0]    mem_write_enable_o
);

  // =====================================================================
  // Host pin synchronisation
  wire [9:0] pins_s;   // Filtered host pins
  wire       rd_s;     // Host read strobe
  wire       wr_s;     // Host write strobe
  wire       iosel_s;  // Board I/O window selected
  wire [4:0] ioadr_s;  // I/O address within window
  wire       ube_s;    // Upper-lane bus enable
  wire       dma_s;    // DMA acknowledge

  ppdm_pin_sync #(
    .WIDTH (10)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   ({host_read_strobe_i, host_write_strobe_i, host_io_select_i,
               host_io_addr_i, upper_lane_bus_enable_i, host_dma_ack_i}),
    .level_o (pins_s)
  );

  assign rd_s    = pins_s[9];
  assign wr_s    = pins_s[8];
  assign iosel_s = pins_s[7];
  assign ioadr_s = pins_s[6:2];
  assign ube_s   = pins_s[1];
  assign dma_s   = pins_s[0];

  // =====================================================================
  // Software-visible state
  reg [7:0]    instr;       // Instruction register image
  reg [CW-1:0] host_cnt;    // Fly-by host address counter
  reg          byte_host;   // Host port is byte wide
  reg          bank_pend;   // Requested bank from instruction bit 7
  reg          bank;        // 0: DSP on left, host on right
  reg          byte_phase;  // Low byte taken, high byte awaited
  reg          acc_prev;    // Host access active last cycle
  reg          hi_prev;     // Last access was a high-byte access

  // =====================================================================
  // Host access decode
  wire sel_high;    // High-byte data address decoded
  wire sel_low;     // Low-byte data address decoded
  wire dma_ok;      // DMA cycle, only honoured on a word-wide host
  wire word_xfer;   // Whole 16-bit word moves in this access
  wire host_acc;    // Any host memory access in progress
  wire acc_end;     // Host access just finished
  wire wb_hit;      // Bus request waiting for its answer
  wire wb_wr;       // Bus write accepted this cycle

  assign sel_high  = iosel_s & (ioadr_s == `PPDM_IO_HIGH_ADDR);
  assign sel_low   = iosel_s & (ioadr_s == `PPDM_IO_LOW_ADDR);
  // Byte-wide hosts cannot use DMA; such acknowledges are ignored
  assign dma_ok    = dma_s & ~byte_host;
  assign word_xfer = dma_ok | (~byte_host & ube_s);
  assign host_acc  = (rd_s | wr_s) & (dma_ok | sel_high | sel_low);
  assign acc_end   = acc_prev & ~host_acc;
  assign wb_hit    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr     = wb_hit & wb_we_i;

  // =====================================================================
  // Wishbone slave: one wait state, ack for one cycle, unmapped reads 0
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          `PPDM_OFF_INSTR: begin
            wb_dat_o <= {24'h000000, instr};
          end
          `PPDM_OFF_HADDR: begin
            wb_dat_o <= {{(32-CW){1'b0}}, host_cnt};
          end
          `PPDM_OFF_CTRL: begin
            wb_dat_o <= {31'h00000000, byte_host};
          end
          `PPDM_OFF_STATUS: begin
            wb_dat_o <= {27'h0000000, dsp_run_i, host_acc, byte_phase,
                         bank_pend, bank};
          end
          default: begin
            wb_dat_o <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // =====================================================================
  // Instruction and control registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      instr     <= `PPDM_INSTR_RST;
      byte_host <= `PPDM_CTRL_RST;
      bank_pend <= `PPDM_BANK_RST;
    end else if (wb_wr) begin
      if (wb_adr_i == `PPDM_OFF_INSTR && wb_sel_i[0]) begin
        instr     <= wb_dat_i[7:0];
        bank_pend <= wb_dat_i[`PPDM_INSTR_BANK_BIT];
      end
      if (wb_adr_i == `PPDM_OFF_CTRL && wb_sel_i[0]) begin
        byte_host <= wb_dat_i[`PPDM_CTRL_BYTE_BIT];
      end
    end
  end

  // =====================================================================
  // Bank select latch
  // A swap waits for an idle DSP and an idle host, so no access is torn
  always @(posedge clk_i) begin
    if (rst_i) begin
      bank <= `PPDM_BANK_RST;
    end else if (!dsp_run_i && !host_acc && !acc_prev) begin
      bank <= bank_pend;
    end
  end

  // =====================================================================
  // Fly-by counter and byte sequencing
  // Bit 0 picks real or imaginary; bits 10 to 1 address the bank
  always @(posedge clk_i) begin
    if (rst_i) begin
      host_cnt   <= `PPDM_HADDR_RST;
      byte_phase <= 1'b0;
      acc_prev   <= 1'b0;
      hi_prev    <= 1'b0;
    end else begin
      acc_prev <= host_acc;
      if (host_acc) begin
        hi_prev <= sel_high & ~word_xfer;
      end
      if (wb_wr && wb_adr_i == `PPDM_OFF_HADDR) begin
        // Preload wins over a finishing access: software owns the start
        if (wb_sel_i[0]) begin
          host_cnt[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          host_cnt[CW-1:8] <= wb_dat_i[CW-1:8];
        end
        byte_phase <= 1'b0;
      end else if (acc_end) begin
        if (!byte_host || dma_ok) begin
          // Word transfers step on every access
          host_cnt <= host_cnt + {{(CW-1){1'b0}}, 1'b1};
        end else if (hi_prev) begin
          // Byte transfers step once per low/high pair
          host_cnt   <= host_cnt + {{(CW-1){1'b0}}, 1'b1};
          byte_phase <= 1'b0;
        end else begin
          byte_phase <= 1'b1;
        end
      end
    end
  end

  // =====================================================================
  // Next-state logic for the pin-facing outputs
  reg       next_word_lane;   // Lanes 1 and 3
  reg       next_high_lane;   // Lane 2
  reg [7:0] next_we;          // Memory write enables
  reg [3:0] next_host_ce;     // {right imag, right real, left imag, left real}
  reg [1:0] host_bytes;       // {high, low} byte lanes written by host
  reg       host_imag;        // Host half chosen by counter bit 0
  reg [2:0] host_lane0;       // Base lane index for host bank/half
  integer   i;                // Loop index

  always @* begin
    next_word_lane = 1'b0;
    next_high_lane = 1'b0;
    next_we        = 8'h00;
    next_host_ce   = 4'h0;
    host_bytes     = 2'b00;
    host_imag      = host_cnt[0];
    host_lane0     = {~bank, host_imag, 1'b0};
    if (host_acc) begin
      if (word_xfer) begin
        next_word_lane = 1'b1;
        host_bytes     = 2'b11;
      end else if (sel_low) begin
        // Lane 3 also opens here, carrying a junk high byte
        next_word_lane = 1'b1;
        host_bytes     = 2'b01;
      end else begin
        next_high_lane = 1'b1;
        host_bytes     = 2'b10;
      end
      next_host_ce[{~bank, host_imag}] = 1'b1;
    end
    // Host writes go to the bank not under processing
    if (wr_s && host_acc) begin
      next_we[host_lane0]     = host_bytes[0];
      next_we[host_lane0 + 3'h1] = host_bytes[1];
    end
    // DSP writes are always whole words on its own bank
    for (i = 0; i < 2; i = i + 1) begin
      next_we[{bank, 1'b0, i[0]}] = ucode_we_real_i;
      next_we[{bank, 1'b1, i[0]}] = ucode_we_imag_i;
    end
  end

  // =====================================================================
  // Registered outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      left_addr_from_dsp_o     <= 1'b1;
      right_addr_from_dsp_o    <= 1'b0;
      host_mem_addr_o          <= {AW{1'b0}};
      dsp_left_xcvr_enable_o   <= 1'b0;
      dsp_right_xcvr_enable_o  <= 1'b0;
      dsp_real_xcvr_to_mem_o   <= 1'b0;
      dsp_imag_xcvr_to_mem_o   <= 1'b0;
      shifter_real_oe_o        <= 1'b0;
      shifter_imag_oe_o        <= 1'b0;
      return_real_oe_o         <= 1'b0;
      return_imag_oe_o         <= 1'b0;
      word_lane_xcvr_enable_o  <= 1'b0;
      high_lane_xcvr_enable_o  <= 1'b0;
      host_lane_to_host_o      <= 1'b0;
      left_real_host_enable_o  <= 1'b0;
      left_imag_host_enable_o  <= 1'b0;
      right_real_host_enable_o <= 1'b0;
      right_imag_host_enable_o <= 1'b0;
      mem_write_enable_o       <= 8'h00;
    end else begin
      // Address buses swap with the bank latch
      left_addr_from_dsp_o     <= ~bank;
      right_addr_from_dsp_o    <= bank;
      host_mem_addr_o          <= host_cnt[AW:1];
      // Only the processed bank's DSP transceivers open
      dsp_left_xcvr_enable_o   <= ~bank;
      dsp_right_xcvr_enable_o  <= bank;
      dsp_real_xcvr_to_mem_o   <= ucode_we_real_i;
      dsp_imag_xcvr_to_mem_o   <= ucode_we_imag_i;
      // Shifters drive on reads, return buffers on writes; never both
      shifter_real_oe_o        <= ~ucode_we_real_i;
      shifter_imag_oe_o        <= ~ucode_we_imag_i;
      return_real_oe_o         <= ucode_we_real_i;
      return_imag_oe_o         <= ucode_we_imag_i;
      word_lane_xcvr_enable_o  <= next_word_lane;
      high_lane_xcvr_enable_o  <= next_high_lane;
      // Inward unless the host is reading
      host_lane_to_host_o      <= rd_s;
      left_real_host_enable_o  <= next_host_ce[0];
      left_imag_host_enable_o  <= next_host_ce[1];
      right_real_host_enable_o <= next_host_ce[2];
      right_imag_host_enable_o <= next_host_ce[3];
      mem_write_enable_o       <= next_we;
    end
  end

endmodule

`default_nettype wire

// file: testbench/ppdm_ctrl_chk.sv
// Port-level checker for the ping-pong data memory control block
`timescale 1ns/1ps
`default_nettype none
module ppdm_chk (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       host_read_strobe_i,
  input wire logic       ucode_we_real_i,
  input wire logic       dsp_run_i,
  input wire logic       left_addr_from_dsp_o,
  input wire logic       right_addr_from_dsp_o,
  input wire logic       dsp_left_xcvr_enable_o,
  input wire logic       dsp_right_xcvr_enable_o,
  input wire logic       dsp_real_xcvr_to_mem_o,
  input wire logic       shifter_real_oe_o,
  input wire logic       return_real_oe_o,
  input wire logic       word_lane_xcvr_enable_o,
  input wire logic       high_lane_xcvr_enable_o,
  input wire logic       host_lane_to_host_o,
  input wire logic       left_real_host_enable_o,
  input wire logic       left_imag_host_enable_o,
  input wire logic       right_real_host_enable_o,
  input wire logic       right_imag_host_enable_o,
  input wire logic [7:0] mem_write_enable_o
);
  // =============================================================
  // Clocking: one domain, reset masks everything
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Run held two edges, so no bank swap can be in flight
  sequence s_dsp_steady;
    dsp_run_i [*2];
  endsequence
  // Read pin low long enough to have crossed the synchroniser
  sequence s_read_idle;
    !host_read_strobe_i [*6];
  endsequence
  // =============================================================
  // Bank steering and direction
  a_bank_addr_swap: assert property (
    left_addr_from_dsp_o != right_addr_from_dsp_o) else $error("address buses not split");
  a_dsp_xcvr_bank: assert property (!rst_i |=>
    dsp_left_xcvr_enable_o == left_addr_from_dsp_o
    && dsp_right_xcvr_enable_o == right_addr_from_dsp_o) else $error("wrong DSP bank xcvr");
  a_dsp_dir_follow: assert property (1'h1 |=>
    dsp_real_xcvr_to_mem_o == $past(ucode_we_real_i)) else $error("DSP xcvr direction");
  a_no_bus_fight: assert property (!rst_i |=>
    shifter_real_oe_o != return_real_oe_o) else $error("shifter and buffer both on");
  a_read_dir_idle: assert property (s_read_idle |->
    !host_lane_to_host_o) else $error("host lanes face out with no read");
  a_host_ce_bank: assert property (
    $onehot0({left_real_host_enable_o, left_imag_host_enable_o,
              right_real_host_enable_o, right_imag_host_enable_o})
    && (!(left_real_host_enable_o || left_imag_host_enable_o) || right_addr_from_dsp_o)
    && (!(right_real_host_enable_o || right_imag_host_enable_o) || left_addr_from_dsp_o))
    else $error("host chip enable on wrong bank");
  a_dsp_we_bank: assert property (s_dsp_steady ##0 ucode_we_real_i |=>
    (left_addr_from_dsp_o ? mem_write_enable_o[1:0] : mem_write_enable_o[5:4]) == 2'h3)
    else $error("DSP write not a whole word");
  a_lane_exclusive: assert property (
    !(high_lane_xcvr_enable_o && word_lane_xcvr_enable_o)) else $error("both host lanes on");
endmodule

bind ppdm_ctrl ppdm_chk ppdm_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .host_read_strobe_i(host_read_strobe_i),
  .ucode_we_real_i(ucode_we_real_i), .dsp_run_i(dsp_run_i),
  .left_addr_from_dsp_o(left_addr_from_dsp_o), .right_addr_from_dsp_o(right_addr_from_dsp_o),
  .dsp_left_xcvr_enable_o(dsp_left_xcvr_enable_o),
  .dsp_right_xcvr_enable_o(dsp_right_xcvr_enable_o),
  .dsp_real_xcvr_to_mem_o(dsp_real_xcvr_to_mem_o),
  .shifter_real_oe_o(shifter_real_oe_o), .return_real_oe_o(return_real_oe_o),
  .word_lane_xcvr_enable_o(word_lane_xcvr_enable_o),
  .high_lane_xcvr_enable_o(high_lane_xcvr_enable_o),
  .host_lane_to_host_o(host_lane_to_host_o),
  .left_real_host_enable_o(left_real_host_enable_o),
  .left_imag_host_enable_o(left_imag_host_enable_o),
  .right_real_host_enable_o(right_real_host_enable_o),
  .right_imag_host_enable_o(right_imag_host_enable_o),
  .mem_write_enable_o(mem_write_enable_o));
`default_nettype wire

// file: testbench/ppdm_host_model.sv
// Behavioural host bus with a fly-by DMA channel, driving the board's host pins
`timescale 1ns/1ps
`default_nettype none
module ppdm_host_model #(
  parameter int HOLD = 8,  // Strobe high clocks, twice the synchroniser lag
  parameter int GAP  = 10  // Low clocks before the next access, above the four needed
) (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic       rd_i,
  input  wire logic       dma_i,
  input  wire logic       ube_i,
  input  wire logic [4:0] addr_i,
  output logic            busy_o = 1'h0,
  output logic            rd_o = 1'h0,
  output logic            wr_o = 1'h0,
  output logic            sel_o = 1'h0,
  output logic [4:0]      addr_o = 5'h0,
  output logic            ube_o = 1'h0,
  output logic            dack_o = 1'h0
);
  int cnt = 0;  // Clocks since the access began
  // =============================================================
  // Access sequencer: strobe falls first, qualifiers let go later
  always @(posedge clk_i) begin
    if (go_i && !busy_o) begin
      busy_o <= 1'h1;
      cnt    <= 0;
      rd_o   <= rd_i;
      wr_o   <= !rd_i;
      sel_o  <= !dma_i;         // Fly-by DMA needs no window decode
      addr_o <= addr_i;
      ube_o  <= ube_i || dma_i;
      dack_o <= dma_i;
    end else if (busy_o) begin
      cnt <= cnt + 1;
      if (cnt == HOLD - 1) begin
        rd_o <= 1'h0;
        wr_o <= 1'h0;
      end
      // Pulled lines idle low; the address floats, so show a changed value
      if (cnt == HOLD + 1) begin
        sel_o  <= 1'h0;
        ube_o  <= 1'h0;
        dack_o <= 1'h0;
        addr_o <= ~addr_o;
      end
      if (cnt == HOLD + GAP) busy_o <= 1'h0;
    end
  end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the ping-pong data memory control block
`timescale 1ns/1ps
`default_nettype none
`include "ppdm_map.vh"
module testbench;
  // =============================================================
  // Stimulus, design outputs and models
  logic        clk_i, rst_i = 1'h1;
  logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
  logic        ucode_we_real_i = 1'h0, ucode_we_imag_i = 1'h0, dsp_run_i = 1'h0;
  logic        h_go = 1'h0, h_rd = 1'h0, h_dma = 1'h0, h_ube = 1'h0, h_busy;
  logic [4:0]  h_ad = 5'h0, io_addr;
  logic        rd_pin, wr_pin, sel_pin, ube_pin, dack_pin;
  logic        l_dsp, r_dsp, dl_x, dr_x, re_x, im_x, sh_r, sh_i, rt_r, rt_i;
  logic        word_ln, high_ln, to_host, ce_lr, ce_li, ce_rr, ce_ri, wr, wi;
  logic [9:0]  hma;
  logic [7:0]  mwe;
  logic [1:0]  k;
  logic        bk = 1'h0, byt = 1'h0; // Bank flag and host width as software set them
  logic [11:0] cnt;                   // Fly-by counter as the bench expects it
  integer      seed = 5905;
  int          failures = 0, n_compared = 0;

  ppdm_ctrl ppdm_ctrl_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .host_read_strobe_i(rd_pin),
    .host_write_strobe_i(wr_pin), .host_io_select_i(sel_pin), .host_io_addr_i(io_addr),
    .upper_lane_bus_enable_i(ube_pin), .host_dma_ack_i(dack_pin),
    .ucode_we_real_i(ucode_we_real_i), .ucode_we_imag_i(ucode_we_imag_i),
    .dsp_run_i(dsp_run_i), .left_addr_from_dsp_o(l_dsp), .right_addr_from_dsp_o(r_dsp),
    .host_mem_addr_o(hma), .dsp_left_xcvr_enable_o(dl_x), .dsp_right_xcvr_enable_o(dr_x),
    .dsp_real_xcvr_to_mem_o(re_x), .dsp_imag_xcvr_to_mem_o(im_x),
    .shifter_real_oe_o(sh_r), .shifter_imag_oe_o(sh_i), .return_real_oe_o(rt_r),
    .return_imag_oe_o(rt_i), .word_lane_xcvr_enable_o(word_ln),
    .high_lane_xcvr_enable_o(high_ln), .host_lane_to_host_o(to_host),
    .left_real_host_enable_o(ce_lr), .left_imag_host_enable_o(ce_li),
    .right_real_host_enable_o(ce_rr), .right_imag_host_enable_o(ce_ri),
    .mem_write_enable_o(mwe));

  ppdm_host_model ppdm_host_model_inst (
    .clk_i(clk_i), .go_i(h_go), .rd_i(h_rd), .dma_i(h_dma), .ube_i(h_ube), .addr_i(h_ad),
    .busy_o(h_busy), .rd_o(rd_pin), .wr_o(wr_pin), .sel_o(sel_pin), .addr_o(io_addr),
    .ube_o(ube_pin), .dack_o(dack_pin));

  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end

  // =============================================================
  // Expectations: host access gives {chip enables, lanes, write enables}
  function automatic logic [14:0] host_exp(input logic rd, input logic lo, input logic hf);
    logic [1:0] by;
    by = !byt ? 2'h3 : (lo ? 2'h1 : 2'h2);   // Host owns the bank not processed
    host_exp[14:11] = 4'h1 << {~bk, hf};
    host_exp[10:8]  = {rd, byt && !lo, !byt || lo};
    host_exp[7:0]   = rd ? 8'h00 : ({6'h00, by} << {~bk, hf, 1'h0});
  endfunction
  // DSP microword gives {directions, output enables, write enables}
  function automatic logic [13:0] dsp_exp(input logic r, input logic i);
    dsp_exp[13:8] = {r, i, !r, !i, r, i};
    dsp_exp[7:0]  = {4'h0, i, i, r, r} << {bk, 2'h0};
  endfunction

  // =============================================================
  // Compare, verdict, bus tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    for (int n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'h1) break;
    end
    check(wb_ack_o, 1'h1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  // One host access; ORs what the lanes did while it lasted
  task automatic host(input logic rd, input logic dma, input logic [4:0] ad);
    logic [14:0] seen;
    logic        ok, lo;
    seen = 15'h0;
    lo   = (ad == `PPDM_IO_LOW_ADDR);
    ok   = !(dma && byt);                 // Byte hosts get no DMA
    @(posedge clk_i);
    h_go  <= 1'h1;
    h_rd  <= rd;
    h_dma <= dma;
    h_ube <= !byt;
    h_ad  <= ad;
    @(posedge clk_i);
    h_go <= 1'h0;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk_i);
      seen = seen | {ce_ri, ce_rr, ce_li, ce_lr, to_host, high_ln, word_ln, mwe};
      if (h_busy !== 1'h1) break;
    end
    check(seen, ok ? host_exp(rd, lo, cnt[0]) : 15'h0);
    if (ok && (!byt || !lo)) cnt = cnt + 12'h1;
    check(hma, cnt[10:1]);
  endtask

  // =============================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    check({l_dsp, r_dsp, dl_x, dr_x, to_host, mwe}, 13'h1400);
    wb(4'h2, 1'h0, 32'h0);
    check(rdat, 32'h0);
    cnt = 12'($random(seed));
    wb(`PPDM_OFF_HADDR, 1'h1, {20'h0, cnt});
    for (int p = 0; p < 2; p++) begin
      // Processing run with random microword writes
      dsp_run_i <= 1'h1;
      for (int i = 0; i < 10; i++) begin
        {wr, wi} = 2'($random(seed));
        ucode_we_real_i <= wr;
        ucode_we_imag_i <= wi;
        repeat (2) @(posedge clk_i);
        check({re_x, im_x, sh_r, sh_i, rt_r, rt_i, mwe}, dsp_exp(wr, wi));
      end
      // Swap asked for mid-run must wait for the run to end
      wb(`PPDM_OFF_INSTR, 1'h1, {24'h0, !bk, 7'h0});
      repeat (4) @(posedge clk_i);
      check(l_dsp, !bk);
      dsp_run_i <= 1'h0;
      ucode_we_real_i <= 1'h0;
      ucode_we_imag_i <= 1'h0;
      bk = !bk;
      repeat (4) @(posedge clk_i);
      check({l_dsp, r_dsp, dl_x, dr_x}, {!bk, bk, !bk, bk});
      wb(`PPDM_OFF_STATUS, 1'h0, 32'h0);
      check(rdat, {30'h0, bk, bk});
      // Unload and reload the other bank: words first, then bytes
      byt = p[0];
      wb(`PPDM_OFF_CTRL, 1'h1, {31'h0, byt});
      for (int i = 0; i < 6; i++) begin
        k = 2'($unsigned($random(seed)) % 3);
        if (byt) host(i == 2, i == 5, i[0] ? `PPDM_IO_HIGH_ADDR : `PPDM_IO_LOW_ADDR);
        else host(k == 2'h1, k == 2'h2, `PPDM_IO_HIGH_ADDR);
      end
    end
    // Last byte access was a low byte, so the high byte is still awaited
    wb(`PPDM_OFF_STATUS, 1'h0, 32'h0);
    check(rdat, {29'h0, 1'h1, bk, bk});
    wb(`PPDM_OFF_HADDR, 1'h0, 32'h0);
    check(rdat, {20'h0, cnt});
    summarize();
  end

  // Watchdog: the run needs about 350 clocks
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
